// file: logic/spi_quad_pin_defs.svh
// offsets, field positions and reset values for the shared serial pin mux
`ifndef SPI_QUAD_PIN_DEFS_SVH
`define SPI_QUAD_PIN_DEFS_SVH

// ----------------------------------------------------------------
// pad slots inside the three-pin vectors
// ----------------------------------------------------------------
`define PAD_E6 0
`define PAD_E7 1
`define PAD_C0 2

// ----------------------------------------------------------------
// bit positions in the port and select words
// ----------------------------------------------------------------
`define PE_MISO_BIT 6
`define PE_SS_BIT 7
`define PC_PHASE_BIT 0
`define GPS_PHASE_A_ALT_BIT 0

// ----------------------------------------------------------------
// reset values: all peripheral functions, inputs, pull-ups on
// ----------------------------------------------------------------
`define PULLUP_RST 8'hff
`define PERIPH_RST 8'hff
`define DIR_RST 8'h00
`define DOUT_RST 8'h00
`define GPS_RST 16'h0000

`endif

// file: logic/spi_quad_pin_pkg.sv
// types shared by the shared serial pin mux modules
`default_nettype none

package spi_quad_pin_pkg;

  // function carried by the shared decoder-phase pin
  typedef enum logic [1:0] {
    C0_GPIO,
    C0_DECODER_TIMER,
    C0_SERIAL_CLOCK
  } c0_func_t;

  // software configuration held by the block
  typedef struct packed {
    logic [7:0]  pe_pull;
    logic [7:0]  pc_pull;
    logic [7:0]  pe_periph;
    logic [7:0]  pc_periph;
    logic [7:0]  pe_dir;
    logic [7:0]  pc_dir;
    logic [7:0]  pe_dout;
    logic [7:0]  pc_dout;
    logic [15:0] gps;
  } pin_cfg_t;

  // state register of the mux top
  typedef struct packed {
    pin_cfg_t   cfg;
    logic [2:0] pad_out;
    logic [2:0] pad_oe;
    logic [2:0] pad_pull;
    logic [2:0] gpio_in;
    logic       ss_active;
    logic       miso_in;
    logic       phase_a;
    logic       timer_in;
    logic       port1_clk_in;
  } pin_state_t;

endpackage

`default_nettype wire

// file: logic/pin_sync.sv
// two-flop synchroniser for pad inputs
`timescale 1ns/100ps
`default_nettype none

module pin_sync
#(
  parameter int WIDTH = 3 // number of pads
)
(
  input  wire logic             i_clk, // system clock
  input  wire logic             i_rst, // sync reset, high
  input  wire logic [WIDTH-1:0] i_d,   // raw pad levels
  output var  logic [WIDTH-1:0] o_q    // synchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  // first stage is read only by the second; pads idle high (pull-ups)
  always_comb
  begin
    st_next.s1 = i_d;
    st_next.s2 = st_reg.s1;
    if (i_rst)
    begin
      st_next = '1;
    end
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    st_reg <= st_next;
  end

  assign o_q = st_reg.s2;

endmodule

`default_nettype wire

// file: logic/half_cycle_launch.sv
// launches a serial bit on the falling clock edge, half a cycle before sampling
`timescale 1ns/100ps
`default_nettype none

module half_cycle_launch
(
  input  wire logic i_clk,         // system clock
  input  wire logic i_rst,         // sync reset, high
  input  wire logic i_clock_level, // serial clock level, same domain
  input  wire logic i_bit,         // next bit to present
  output var  logic o_bit          // launched bit, from a flop
);

  typedef struct packed {
    logic prev;
    logic data;
  } launch_state_t;

  launch_state_t st_reg;
  launch_state_t st_next;

  // launch on the falling edge so the bit settles before the rising sample edge
  always_comb
  begin
    st_next.prev = i_clock_level;
    st_next.data = st_reg.data;
    if (st_reg.prev && !i_clock_level)
    begin
      st_next.data = i_bit;
    end
    if (i_rst)
    begin
      st_next = '0;
    end
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    st_reg <= st_next;
  end

  assign o_bit = st_reg.data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_launch_on_fall;
    @(posedge i_clk) disable iff (i_rst)
    $changed(o_bit) |-> $past(st_reg.prev && !i_clock_level);
  endproperty
  a_launch_on_fall: assert property (p_launch_on_fall) else $error("bit moved outside a falling edge");

  property p_stable_at_sample;
    @(posedge i_clk) disable iff (i_rst)
    $rose(i_clock_level) |=> $stable(o_bit);
  endproperty
  a_stable_at_sample: assert property (p_stable_at_sample) else $error("bit moved at sample edge");

endmodule

`default_nettype wire

// file: logic/spi_quad_pin_function_select.sv
// pin function select and pull-up control for three shared serial pins
//
// Functional notes
// - unselected serial slave floats its slave data output pin.
// - slave bit appears half a serial clock before master samples it.
// - slave select pin marks the current transfer as one to receive.
// - port 1 clock pin drives clock as master, takes clock as slave.
// - shared phase pin carries port 1 clock only with alternate bit set.
// - each pin is a plain input or output when its gpio function is chosen.
// - after reset port E pin six is port 0 slave data out.
// - after reset port E pin seven is port 0 slave select.
// - full variant: port C pin zero defaults to decoder 1 phase A.
// - clearing port E pull-up bit 6 turns off slave data pull-up.
// - clearing port E pull-up bit 7 turns off slave select pull-up.
// - clearing port C pull-up bit 0 turns off phase pin pull-up.
// - master bit appears half a serial clock before slave samples it.
`timescale 1ns/100ps
`default_nettype none
`include "spi_quad_pin_defs.svh"

module spi_quad_pin_function_select
  import spi_quad_pin_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1 // 0 = reduced part without decoder 1
)
(
  input  wire logic        i_clk,                       // 10 mhz system clock
  input  wire logic        i_rst,                       // sync reset, high
  input  wire logic [2:0]  i_pad_in,                    // pad levels e6, e7, c0
  output var  logic [2:0]  o_pad_out,                   // pad drive value
  output var  logic [2:0]  o_pad_oe,                    // pad drive enable
  output var  logic [2:0]  o_pad_pullup,                // pad pull-up enable
  input  wire logic        i_cfg_wr,                    // config write pulse
  input  wire logic [7:0]  i_port_e_pullup_enable,      // port e pull-ups
  input  wire logic [7:0]  i_port_c_pullup_enable,      // port c pull-ups
  input  wire logic [7:0]  i_port_e_periph_enable,      // 1 = peripheral function
  input  wire logic [7:0]  i_port_c_periph_enable,      // 1 = peripheral function
  input  wire logic [7:0]  i_port_e_dir,                // 1 = gpio output
  input  wire logic [7:0]  i_port_c_dir,                // 1 = gpio output
  input  wire logic [7:0]  i_port_e_data,               // gpio drive data
  input  wire logic [7:0]  i_port_c_data,               // gpio drive data
  input  wire logic [15:0] i_system_gpio_select_register, // alternate selects
  input  wire logic        i_spi0_master_mode,          // port 0 is master
  input  wire logic        i_spi0_clock_level,          // port 0 serial clock
  input  wire logic        i_spi0_slave_bit,            // next slave out bit
  input  wire logic        i_spi0_master_bit,           // next master out bit
  input  wire logic        i_spi1_master_mode,          // port 1 is master
  input  wire logic        i_spi1_clock_out,            // port 1 clock as master
  input  wire logic        i_timer_b0_out,              // timer b ch 0 drive
  input  wire logic        i_timer_b0_oe,               // timer b ch 0 enable
  output var  logic        o_port0_slave_select,        // transfer addressed here
  output var  logic        o_port0_master_data_in,      // slave data as master
  output var  logic        o_port0_master_data_out,     // master data bit
  output var  logic        o_decoder1_phase_a_in,       // decoder 1 phase a
  output var  logic        o_timer_b_channel_zero,      // timer b ch 0 input
  output var  logic        o_port1_serial_clock,        // port 1 clock as slave
  output var  logic [2:0]  o_gpio_in                    // gpio read levels
);

  pin_state_t st_reg;
  pin_state_t st_next;
  logic [2:0] syn;
  logic       slave_bit;
  logic       ss_now;
  c0_func_t   c0_now;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // decoding of the shared phase pin, used by logic and checks
  function automatic c0_func_t c0_func(input logic periph, input logic alt);
    c0_func_t f;
    f = C0_GPIO;
    if (periph && alt)
    begin
      f = C0_SERIAL_CLOCK;
    end
    else if (periph)
    begin
      f = C0_DECODER_TIMER;
    end
    return f;
  endfunction

  // pad levels come from outside the clock domain
  pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (i_pad_in),
    .o_q   (syn)
  );

  // slave data out, launched on falling clock
  half_cycle_launch u_slave_launch (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_clock_level (i_spi0_clock_level),
    .i_bit         (i_spi0_slave_bit),
    .o_bit         (slave_bit)
  );

  // master data out, same half-cycle lead for the far slave
  half_cycle_launch u_master_launch (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_clock_level (i_spi0_clock_level),
    .i_bit         (i_spi0_master_bit),
    .o_bit         (o_port0_master_data_out)
  );

  // slave select is active low; only meaningful as a slave
  assign ss_now = st_reg.cfg.pe_periph[`PE_SS_BIT] && !syn[`PAD_E7]
                  && !i_spi0_master_mode;
  assign c0_now = c0_func(st_reg.cfg.pc_periph[`PC_PHASE_BIT],
                          st_reg.cfg.gps[`GPS_PHASE_A_ALT_BIT]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // config takes effect on pads one cycle after it is stored
    if (i_cfg_wr)
    begin
      st_next.cfg.pe_pull   = i_port_e_pullup_enable;
      st_next.cfg.pc_pull   = i_port_c_pullup_enable;
      st_next.cfg.pe_periph = i_port_e_periph_enable;
      st_next.cfg.pc_periph = i_port_c_periph_enable;
      st_next.cfg.pe_dir    = i_port_e_dir;
      st_next.cfg.pc_dir    = i_port_c_dir;
      st_next.cfg.pe_dout   = i_port_e_data;
      st_next.cfg.pc_dout   = i_port_c_data;
      st_next.cfg.gps       = i_system_gpio_select_register;
    end

    // pull-ups follow their enable bits directly
    st_next.pad_pull[`PAD_E6] = st_reg.cfg.pe_pull[`PE_MISO_BIT];
    st_next.pad_pull[`PAD_E7] = st_reg.cfg.pe_pull[`PE_SS_BIT];
    st_next.pad_pull[`PAD_C0] = st_reg.cfg.pc_pull[`PC_PHASE_BIT];
    st_next.gpio_in   = syn;
    st_next.ss_active = ss_now;
    st_next.miso_in   = 1'b0;

    // port e pin six: slave data out, master data in, or gpio
    if (st_reg.cfg.pe_periph[`PE_MISO_BIT])
    begin
      st_next.pad_out[`PAD_E6] = slave_bit;
      st_next.pad_oe[`PAD_E6]  = ss_now;
      if (i_spi0_master_mode)
      begin
        st_next.miso_in = syn[`PAD_E6];
      end
    end
    else
    begin
      st_next.pad_out[`PAD_E6] = st_reg.cfg.pe_dout[`PE_MISO_BIT];
      st_next.pad_oe[`PAD_E6]  = st_reg.cfg.pe_dir[`PE_MISO_BIT];
    end

    // port e pin seven: slave select is input only
    if (st_reg.cfg.pe_periph[`PE_SS_BIT])
    begin
      st_next.pad_out[`PAD_E7] = 1'b0;
      st_next.pad_oe[`PAD_E7]  = 1'b0;
    end
    else
    begin
      st_next.pad_out[`PAD_E7] = st_reg.cfg.pe_dout[`PE_SS_BIT];
      st_next.pad_oe[`PAD_E7]  = st_reg.cfg.pe_dir[`PE_SS_BIT];
    end

    // port c pin zero: decoder and timer, port 1 clock, or gpio
    st_next.phase_a      = 1'b0;
    st_next.timer_in     = 1'b0;
    st_next.port1_clk_in = 1'b0;
    case (c0_now)
      C0_SERIAL_CLOCK:
      begin
        // only reachable with the alternate select bit set
        st_next.pad_out[`PAD_C0] = i_spi1_clock_out;
        st_next.pad_oe[`PAD_C0]  = i_spi1_master_mode;
        if (!i_spi1_master_mode)
        begin
          st_next.port1_clk_in = syn[`PAD_C0];
        end
      end
      C0_DECODER_TIMER:
      begin
        // reduced part has no decoder 1, so its input stays idle
        st_next.phase_a  = FULL_VARIANT && syn[`PAD_C0];
        st_next.timer_in = syn[`PAD_C0];
        st_next.pad_out[`PAD_C0] = i_timer_b0_out;
        st_next.pad_oe[`PAD_C0]  = i_timer_b0_oe;
      end
      C0_GPIO:
      begin
        st_next.pad_out[`PAD_C0] = st_reg.cfg.pc_dout[`PC_PHASE_BIT];
        st_next.pad_oe[`PAD_C0]  = st_reg.cfg.pc_dir[`PC_PHASE_BIT];
      end
      default:
      begin
        st_next.pad_out[`PAD_C0] = 1'b0;
        st_next.pad_oe[`PAD_C0]  = 1'b0;
      end
    endcase

    // reset: peripheral functions, all inputs, pull-ups on
    if (i_rst)
    begin
      st_next               = '0;
      st_next.cfg.pe_pull   = `PULLUP_RST;
      st_next.cfg.pc_pull   = `PULLUP_RST;
      st_next.cfg.pe_periph = `PERIPH_RST;
      st_next.cfg.pc_periph = `PERIPH_RST;
      st_next.cfg.pe_dir    = `DIR_RST;
      st_next.cfg.pc_dir    = `DIR_RST;
      st_next.cfg.pe_dout   = `DOUT_RST;
      st_next.cfg.pc_dout   = `DOUT_RST;
      st_next.cfg.gps       = `GPS_RST;
      st_next.pad_pull      = 3'h7;
      st_next.gpio_in       = 3'h7;
    end
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register; master data out comes from u_master_launch
  // ----------------------------------------------------------------
  assign o_pad_out              = st_reg.pad_out;
  assign o_pad_oe               = st_reg.pad_oe;
  assign o_pad_pullup           = st_reg.pad_pull;
  assign o_gpio_in              = st_reg.gpio_in;
  assign o_port0_slave_select   = st_reg.ss_active;
  assign o_port0_master_data_in = st_reg.miso_in;
  assign o_decoder1_phase_a_in  = st_reg.phase_a;
  assign o_timer_b_channel_zero = st_reg.timer_in;
  assign o_port1_serial_clock   = st_reg.port1_clk_in;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_clear_e6;
    i_cfg_wr && !i_port_e_pullup_enable[`PE_MISO_BIT] ##1 !i_cfg_wr;
  endsequence
  sequence s_clear_e7;
    i_cfg_wr && !i_port_e_pullup_enable[`PE_SS_BIT] ##1 !i_cfg_wr;
  endsequence
  sequence s_clear_c0;
    i_cfg_wr && !i_port_c_pullup_enable[`PC_PHASE_BIT] ##1 !i_cfg_wr;
  endsequence

  property p_miso_hiz;
    st_reg.cfg.pe_periph[`PE_MISO_BIT] && !ss_now |=> !o_pad_oe[`PAD_E6];
  endproperty
  a_miso_hiz: assert property (p_miso_hiz) else $error("unselected slave drives data");

  property p_miso_bit;
    st_reg.cfg.pe_periph[`PE_MISO_BIT] && ss_now |=> o_pad_oe[`PAD_E6] && o_pad_out[`PAD_E6] == $past(slave_bit);
  endproperty
  a_miso_bit: assert property (p_miso_bit) else $error("selected slave bit not on pin");

  property p_slave_select;
    st_reg.cfg.pe_periph[`PE_SS_BIT] && !i_spi0_master_mode
    |=> o_port0_slave_select == !$past(syn[`PAD_E7]);
  endproperty
  a_slave_select: assert property (p_slave_select) else $error("slave select not passed on");

  property p_port1_clk_dir;
    c0_now == C0_SERIAL_CLOCK |=> o_pad_oe[`PAD_C0] == $past(i_spi1_master_mode)
    && o_port1_serial_clock == ($past(!i_spi1_master_mode) && $past(syn[`PAD_C0]));
  endproperty
  a_port1_clk_dir: assert property (p_port1_clk_dir) else $error("port 1 clock direction wrong");

  property p_alt_gate;
    !st_reg.cfg.gps[`GPS_PHASE_A_ALT_BIT] |=> !o_port1_serial_clock;
  endproperty
  a_alt_gate: assert property (p_alt_gate) else $error("clock routed without alternate bit");

  property p_gpio_e6;
    !st_reg.cfg.pe_periph[`PE_MISO_BIT] |=> o_pad_oe[`PAD_E6] == $past(st_reg.cfg.pe_dir[`PE_MISO_BIT])
    && o_pad_out[`PAD_E6] == $past(st_reg.cfg.pe_dout[`PE_MISO_BIT]);
  endproperty
  a_gpio_e6: assert property (p_gpio_e6) else $error("gpio pin six not as programmed");

  property p_rst_e6;
    $fell(i_rst) |-> st_reg.cfg.pe_periph[`PE_MISO_BIT];
  endproperty
  a_rst_e6: assert property (p_rst_e6) else $error("pin six not slave data after reset");

  property p_rst_e7;
    $fell(i_rst) |-> st_reg.cfg.pe_periph[`PE_SS_BIT];
  endproperty
  a_rst_e7: assert property (p_rst_e7) else $error("pin seven not slave select after reset");

  property p_rst_c0;
    $fell(i_rst) |-> c0_now == C0_DECODER_TIMER;
  endproperty
  a_rst_c0: assert property (p_rst_c0) else $error("pin zero not decoder after reset");

  property p_pull_e6;
    s_clear_e6 |=> !o_pad_pullup[`PAD_E6];
  endproperty
  a_pull_e6: assert property (p_pull_e6) else $error("pin six pull-up stays on");

  property p_pull_e7;
    s_clear_e7 |=> !o_pad_pullup[`PAD_E7];
  endproperty
  a_pull_e7: assert property (p_pull_e7) else $error("pin seven pull-up stays on");

  property p_pull_c0;
    s_clear_c0 |=> !o_pad_pullup[`PAD_C0];
  endproperty
  a_pull_c0: assert property (p_pull_c0) else $error("pin zero pull-up stays on");

  property p_rst_pins;
    $fell(i_rst) |-> o_pad_oe == 3'h0 && o_pad_pullup == 3'h7;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not pulled inputs in reset");

endmodule

`default_nettype wire

// file: dv/pad_partner.sv
// far-side serial peer and pad wire resolver for the shared pins
`timescale 1ns/100ps
`default_nettype none

module pad_partner
(
  input  wire logic       i_clk,        // system clock
  input  wire logic [2:0] i_pad_out,    // design drive value
  input  wire logic [2:0] i_pad_oe,     // design drive enable
  input  wire logic [2:0] i_pad_pullup, // design pull-up enable
  input  wire logic [2:0] i_ext_en,     // far side drives pad
  input  wire logic [2:0] i_ext_val,    // far side drive value
  input  wire logic       i_sclk,       // port 0 serial clock level
  output var  logic [2:0] o_wire,       // resolved pad level
  output var  logic       o_sampled     // slave data taken at clock rise
);
  logic [2:0] last_reg;
  logic       sclk_reg;

  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // a pad nobody drives and nothing pulls shows a changing level,
  // so the design cannot lean on a value the simulator settled for it
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (i_pad_oe[i])
        o_wire[i] = i_pad_out[i];
      else if (i_ext_en[i])
        o_wire[i] = i_ext_val[i];
      else if (i_pad_pullup[i])
        o_wire[i] = 1'b1;
      else
        o_wire[i] = ~last_reg[i];
    end
  end

  // master side samples slave data only on the rising serial clock
  always_ff @(posedge i_clk)
  begin
    last_reg <= o_wire;
    sclk_reg <= i_sclk;
    if (i_sclk && !sclk_reg)
      o_sampled <= o_wire[0];
  end
endmodule

`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the shared serial pin mux
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        i_clk, i_rst, cfg_wr, s0_master, s0_clk, s0_sbit, s0_mbit;
  logic        s1_master, s1_clk, tb_out, tb_oe;
  logic [7:0]  pe_pull, pc_pull, pe_per, pc_per, pe_dir, pc_dir, pe_dat, pc_dat;
  logic [15:0] gps;
  logic [2:0]  pad_wire, pad_out, pad_oe, pad_pu, gpio_in, ext_en, ext_val;
  logic        sel, mdin, mdout, ph_a, tmr, p1_clk, sampled;
  int          miscompares, n_compared;

  spi_quad_pin_function_select #(.FULL_VARIANT(1'b1)) i_spi_quad_pin_function_select (
    .i_clk(i_clk), .i_rst(i_rst), .i_pad_in(pad_wire), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
    .o_pad_pullup(pad_pu), .i_cfg_wr(cfg_wr), .i_port_e_pullup_enable(pe_pull),
    .i_port_c_pullup_enable(pc_pull), .i_port_e_periph_enable(pe_per), .i_port_c_periph_enable(pc_per),
    .i_port_e_dir(pe_dir), .i_port_c_dir(pc_dir), .i_port_e_data(pe_dat), .i_port_c_data(pc_dat),
    .i_system_gpio_select_register(gps), .i_spi0_master_mode(s0_master), .i_spi0_clock_level(s0_clk),
    .i_spi0_slave_bit(s0_sbit), .i_spi0_master_bit(s0_mbit), .i_spi1_master_mode(s1_master),
    .i_spi1_clock_out(s1_clk), .i_timer_b0_out(tb_out), .i_timer_b0_oe(tb_oe),
    .o_port0_slave_select(sel), .o_port0_master_data_in(mdin), .o_port0_master_data_out(mdout),
    .o_decoder1_phase_a_in(ph_a), .o_timer_b_channel_zero(tmr), .o_port1_serial_clock(p1_clk),
    .o_gpio_in(gpio_in));

  pad_partner i_pad_partner (
    .i_clk(i_clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_pad_pullup(pad_pu), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .i_sclk(s0_clk), .o_wire(pad_wire), .o_sampled(sampled));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // inputs always move 10 ns after the rising edge
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      #10;
    end
  endtask

  task automatic cmp(input logic [2:0] got, input logic [2:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write pulse, then room for the stored word to reach the pads
  task automatic cfg;
    cfg_wr = 1'b1;
    step(1);
    cfg_wr = 1'b0;
    step(3);
  endtask

  task automatic wrap_up;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    step(2);
    cmp(pad_oe, 3'h0);
    cmp(pad_pu, 3'h7);
    cmp(gpio_in, 3'h7);
    i_rst = 1'b0;
    step(4);
    cmp(pad_oe, 3'h0);
    cmp(sel, 1'b0);
    cmp(ph_a, 1'b1);
    cmp(tmr, 1'b1);
  endtask

  // three bits, each data input flipped mid low phase to prove the launch edge
  task automatic serial_bits(input logic master);
    logic b;
    s0_master = master;
    s0_clk = 1'b1;
    step(4);
    for (int k = 0; k < 3; k++)
    begin
      b = (k != 1);
      s0_clk = 1'b0;
      s0_mbit = master ? b : s0_mbit;
      s0_sbit = master ? s0_sbit : b;
      step(1);
      s0_mbit = master ? ~b : s0_mbit;
      s0_sbit = master ? s0_sbit : ~b;
      step(3);
      cmp(master ? mdout : pad_out[0], b);
      s0_clk = 1'b1;
      step(4);
      cmp(master ? mdout : pad_out[0], b);
      if (!master) cmp(sampled, b);
    end
    s0_master = 1'b0;
  endtask

  task automatic t_slave;
    ext_en[1] = 1'b1;
    ext_val[1] = 1'b0;
    step(4);
    cmp(sel, 1'b1);
    cmp(pad_oe[0], 1'b1);
    serial_bits(1'b0);
    ext_val[1] = 1'b1;
    step(4);
    cmp(sel, 1'b0);
    cmp(pad_oe[0], 1'b0);
  endtask

  task automatic t_master;
    ext_en[0] = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      ext_val[0] = k[0];
      s0_master = 1'b1;
      step(4);
      cmp(mdin, k[0]);
      cmp(pad_oe[0], 1'b0);
    end
    ext_en[0] = 1'b0;
    serial_bits(1'b1);
  endtask

  task automatic t_pullup;
    for (int i = 0; i < 3; i++)
    begin
      pe_pull = 8'hff;
      pc_pull = 8'hff;
      if (i == 0) pe_pull[6] = 1'b0;
      if (i == 1) pe_pull[7] = 1'b0;
      if (i == 2) pc_pull[0] = 1'b0;
      cfg;
      cmp(pad_pu, ~(3'h1 << i));
    end
    pc_pull = 8'hff;
    cfg;
  endtask

  task automatic t_gpio;
    pe_per = 8'h3f;
    pc_per = 8'hfe;
    pe_dir = 8'hc0;
    pc_dir = 8'h01;
    pe_dat = 8'h40;
    pc_dat = 8'h01;
    cfg;
    cmp(pad_oe, 3'h7);
    cmp(pad_out, 3'h5);
    pe_dat = 8'h80;
    pc_dat = 8'h00;
    cfg;
    cmp(pad_out, 3'h2);
    pe_dir = 8'h00;
    pc_dir = 8'h00;
    ext_en = 3'h7;
    ext_val = 3'h5;
    cfg;
    cmp(pad_oe, 3'h0);
    // pad read path lags the release by three edges, one more than cfg waits
    step(1);
    cmp(gpio_in, 3'h5);
    // select pin held low but in gpio function: no transfer
    cmp(sel, 1'b0);
    ext_en = 3'h0;
    pe_per = 8'hff;
    pc_per = 8'hff;
    cfg;
  endtask

  task automatic t_alt;
    gps = 16'h0001;
    s1_master = 1'b1;
    s1_clk = 1'b1;
    cfg;
    cmp({pad_oe[2], pad_out[2]}, 2'h3);
    s1_clk = 1'b0;
    step(2);
    cmp({pad_oe[2], pad_out[2]}, 2'h2);
    s1_master = 1'b0;
    ext_en[2] = 1'b1;
    ext_val[2] = 1'b1;
    step(4);
    cmp({pad_oe[2], p1_clk, ph_a, tmr}, 4'h4);
    gps = 16'h0000;
    cfg;
    step(1);
    cmp({p1_clk, ph_a, tmr}, 3'h3);
    tb_oe = 1'b1;
    step(2);
    cmp({pad_oe[2], pad_out[2]}, 2'h2);
    tb_oe = 1'b0;
    ext_en = 3'h0;
  endtask

  // a mid-run reset must undo a gpio setup and bring the pull-ups back
  task automatic t_mid_reset;
    pe_per = 8'h3f;
    pe_dir = 8'hc0;
    pe_pull = 8'h3f;
    cfg;
    cmp(pad_oe, 3'h3);
    cmp(pad_pu, 3'h4);
    i_rst = 1'b1;
    step(2);
    cmp(pad_oe, 3'h0);
    cmp(pad_pu, 3'h7);
    i_rst = 1'b0;
    step(4);
    cmp(pad_oe, 3'h0);
    cmp(pad_pu, 3'h7);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    miscompares = 0;
    n_compared = 0;
    i_rst = 1'b1;
    cfg_wr = 1'b0;
    {s0_master, s0_clk, s0_sbit, s0_mbit, s1_master, s1_clk, tb_out, tb_oe} = 8'h00;
    {pe_pull, pc_pull, pe_per, pc_per} = 32'hffff_ffff;
    {pe_dir, pc_dir, pe_dat, pc_dat} = 32'h0000_0000;
    gps = 16'h0000;
    ext_en = 3'h0;
    ext_val = 3'h0;
    t_reset;
    t_slave;
    t_master;
    t_pullup;
    t_gpio;
    t_alt;
    t_mid_reset;
    wrap_up;
  end

  // the whole run needs about 140 cycles
  initial
  begin
    #200000;
    miscompares++;
    wrap_up;
  end
endmodule

`default_nettype wire
